//--- verilog/burst_sram_consts.svh
`ifndef BURST_SRAM_CONSTS_SVH
`define BURST_SRAM_CONSTS_SVH
`define ADDR_WIDTH 16
`define DATA_WIDTH 32
`define LANE_COUNT 4
`define LANE_WIDTH 8
`define BURST_BITS 2
`define DEPTH_WORDS 65536
`endif

//--- verilog/burst_sram_pkg.sv
`include "burst_sram_consts.svh"
package burst_sram_pkg;
    typedef struct packed {
        logic [`ADDR_WIDTH-1:0] address;
        logic select_first_n;
        logic select_second;
        logic select_third_n;
        logic write_n;
        logic [`LANE_COUNT-1:0] byte_lane_write_n;
        logic advance_or_load;
    } request_type;
    typedef enum logic [1:0] {
        PHASE_IDLE = 2'b00,
        PHASE_READ = 2'b01,
        PHASE_WRITE = 2'b10
    } phase_type;
endpackage : burst_sram_pkg

//--- verilog/word_store.sv
`timescale 1ns/1ps
`default_nettype none
module word_store #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 32,
    parameter int LANES = 4
) (
    input wire logic ref_clk,
    input wire logic write_en,
    input wire logic [ADDR_W-1:0] write_addr,
    input wire logic [LANES-1:0] lane_en,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic [ADDR_W-1:0] read_addr,
    output logic [DATA_W-1:0] read_data
);
    localparam int LANE_W = DATA_W / LANES;
    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            always_ff @(posedge ref_clk) begin
                if (write_en && lane_en[g]) begin
                    cells[write_addr][g*LANE_W +: LANE_W] <= write_data[g*LANE_W +: LANE_W];
                end
            end
        end
    endgenerate
    // Registered read port
    always_ff @(posedge ref_clk) begin
        read_data <= cells[read_addr];
    end
endmodule : word_store
`default_nettype wire

//--- verilog/sync_flowthrough_burst_sram.sv
`timescale 1ns/1ps
`default_nettype none
`include "burst_sram_consts.svh"
module sync_flowthrough_burst_sram #(
    parameter int ADDR_W = `ADDR_WIDTH,
    parameter int DATA_W = `DATA_WIDTH,
    parameter int LANES = `LANE_COUNT
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clock_qualify_n,
    input wire burst_sram_pkg::request_type request,
    input wire logic output_enable_n,
    input wire logic burst_interleaved,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n
);
    // ****************************************
    // Input capture
    // ****************************************
    logic selected_now;
    logic [ADDR_W-1:0] burst_addr;
    logic [ADDR_W-1:0] base_addr;
    logic [`BURST_BITS-1:0] burst_step;
    logic [`BURST_BITS-1:0] next_step;
    logic [ADDR_W-1:0] next_addr;
    logic write_now;
    logic [LANES-1:0] next_lanes;
    burst_sram_pkg::phase_type phase;
    burst_sram_pkg::phase_type next_phase;
    logic was_deselected;
    logic [ADDR_W-1:0] data_addr;
    logic [LANES-1:0] data_lanes;
    logic write_pending;
    logic [DATA_W-1:0] store_rd;
    logic held;
    logic mode_latched;
    logic write_commit;
    logic [ADDR_W-1:0] read_target;
    logic bypass_hit;
    logic [LANES-1:0] bypass_lanes;
    logic [DATA_W-1:0] bypass_word;

    assign selected_now = !request.select_first_n && request.select_second && !request.select_third_n;
    assign write_now = !request.write_n;

    // Burst ordering: linear adds, interleaved xors with a step count
    always_comb begin
        next_step = burst_step;
        next_addr = burst_addr;
        if (request.advance_or_load) begin
            next_step = burst_step + 2'h1;
            if (mode_latched) begin
                next_addr = {base_addr[ADDR_W-1:`BURST_BITS], base_addr[`BURST_BITS-1:0] ^ next_step};
            end else begin
                next_addr = {base_addr[ADDR_W-1:`BURST_BITS], base_addr[`BURST_BITS-1:0] + next_step};
            end
        end else begin
            next_step = '0;
            next_addr = request.address;
        end
    end

    always_comb begin
        next_phase = burst_sram_pkg::PHASE_IDLE;
        next_lanes = '0;
        if (request.advance_or_load) begin
            // Advance continues the previous operation type
            next_phase = phase;
            next_lanes = data_lanes;
        end else if (selected_now) begin
            next_phase = write_now ? burst_sram_pkg::PHASE_WRITE : burst_sram_pkg::PHASE_READ;
            next_lanes = write_now ? ~request.byte_lane_write_n : '0;
        end
    end

    // Strap is static; caught once at first clock edge after reset, whether or not clock_qualify_n is low
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            held <= 1'b0;
            mode_latched <= 1'b1;
        end else if (!held) begin
            held <= 1'b1;
            mode_latched <= burst_interleaved;
        end
    end

    // ****************************************
    // Address and control pipeline
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            burst_addr <= '0;
            base_addr <= '0;
            burst_step <= '0;
        end else if (!clock_qualify_n) begin
            burst_addr <= next_addr;
            burst_step <= next_step;
            if (!request.advance_or_load) begin
                base_addr <= request.address;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= burst_sram_pkg::PHASE_IDLE;
            data_lanes <= '0;
            was_deselected <= 1'b1;
        end else if (!clock_qualify_n) begin
            was_deselected <= (phase == burst_sram_pkg::PHASE_IDLE);
            phase <= next_phase;
            data_lanes <= next_lanes;
        end
    end

    // Write data arrives in the cycle after the address; committed at the next qualified edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            write_pending <= 1'b0;
            data_addr <= '0;
        end else if (!clock_qualify_n) begin
            write_pending <= (next_phase == burst_sram_pkg::PHASE_WRITE);
            data_addr <= next_addr;
        end
    end

    // ****************************************
    // Storage and read data
    // ****************************************
    // While frozen the array keeps re-reading the word already taken, so the output stands
    assign write_commit = !clock_qualify_n && phase == burst_sram_pkg::PHASE_WRITE;
    assign read_target = clock_qualify_n ? burst_addr : next_addr;

    word_store #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .LANES(LANES)
    ) store (
        .ref_clk(ref_clk),
        .write_en(write_commit),
        .write_addr(burst_addr),
        .lane_en(data_lanes),
        .write_data(data_in),
        .read_addr(read_target),
        .read_data(store_rd)
    );

    // ****************************************
    // Read-after-write bypass
    // ****************************************
    // A write commit and an array read share one edge; the array returns the old word,
    // so lanes written at that edge are steered around it instead of stalling the bus
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bypass_hit <= 1'b0;
            bypass_lanes <= '0;
            bypass_word <= '0;
        end else if (!clock_qualify_n) begin
            bypass_hit <= write_commit && (burst_addr == read_target);
            bypass_lanes <= data_lanes;
            bypass_word <= data_in;
        end
    end

    // Read data is the word taken at the last qualified edge, one register deep
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : merge
            localparam int LANE_W = DATA_W / LANES;
            assign data_out[lane*LANE_W +: LANE_W] = (bypass_hit && bypass_lanes[lane])
                ? bypass_word[lane*LANE_W +: LANE_W]
                : store_rd[lane*LANE_W +: LANE_W];
        end
    endgenerate

    // Drive enable is combinational so output enable acts without the clock
    assign data_oe_n = output_enable_n
        || phase != burst_sram_pkg::PHASE_READ
        || was_deselected;
endmodule : sync_flowthrough_burst_sram
`default_nettype wire

//--- test/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input wire logic ref_clk,
    input wire logic wr_on,
    input wire logic [31:0] wr_word,
    input wire logic [31:0] data_out,
    input wire logic data_oe_n,
    output logic [31:0] data_in
);
    logic [31:0] last;
    always_ff @(posedge ref_clk) begin
        last <= data_in;
    end
    // Released bus shows the inverse of its last level, never a stale copy
    assign data_in = wr_on ? wr_word : (!data_oe_n ? data_out : ~last);
endmodule : bus_master_model
`default_nettype wire

//--- test/sram_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sram_checker #(parameter int DATA_W = 32) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clock_qualify_n,
    input wire burst_sram_pkg::request_type request,
    input wire logic output_enable_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_n
);
    logic sel;
    logic go;
    logic ld;
    assign sel = !request.select_first_n && request.select_second && !request.select_third_n;
    assign go = !clock_qualify_n;
    assign ld = !request.advance_or_load;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence q_rd; go && sel && ld && request.write_n; endsequence
    sequence q_wr; go && sel && ld && !request.write_n; endsequence
    a_oe_gated: assert property (output_enable_n |-> data_oe_n) else $error("oe gate");
    a_write_float: assert property (q_wr |=> data_oe_n) else $error("write float");
    a_burst_float: assert property (q_wr ##1 (go && !ld) |=> data_oe_n) else $error("burst float");
    a_off_float: assert property (go && !sel |=> data_oe_n) else $error("off float");
    a_emerge_mask: assert property (go && !sel ##1 q_rd |=> data_oe_n) else $error("emerge");
    a_read_drive: assert property (go && sel && ld ##1 q_rd ##1 !output_enable_n |-> !data_oe_n)
        else $error("read drive");
    a_freeze_out: assert property (clock_qualify_n |=> $stable(data_out)) else $error("freeze out");
    a_freeze_oe: assert property (clock_qualify_n ##1 $stable(output_enable_n) |-> $stable(data_oe_n))
        else $error("freeze oe");
endmodule : sram_checker
bind sync_flowthrough_burst_sram sram_checker #(.DATA_W(DATA_W)) sram_checker_i (.ref_clk, .resetn,
    .clock_qualify_n, .request, .output_enable_n, .data_out, .data_oe_n);
`default_nettype wire

//--- test/sync_flowthrough_burst_sram_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sync_flowthrough_burst_sram_tb;
    localparam logic HI = 1'h1;
    localparam logic LO = 1'h0;
    logic ref_clk = 0, resetn = 0, clock_qualify_n = 0, output_enable_n = 0, burst_interleaved = 0;
    logic wr_on = 0, pend = 0, data_oe_n;
    logic [31:0] data_in, data_out, wr_word = 0, pdat = 0;
    burst_sram_pkg::request_type request = '0;
    int failures = 0, checks = 0, cycles = 0;
    sync_flowthrough_burst_sram sync_flowthrough_burst_sram_i (.ref_clk, .resetn, .clock_qualify_n, .request,
        .output_enable_n, .burst_interleaved, .data_in, .data_out, .data_oe_n);
    bus_master_model bus_master_model_i (.ref_clk, .wr_on, .wr_word, .data_out, .data_oe_n, .data_in);
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    function automatic logic [31:0] pat(input logic [15:0] a);
        return {16'hA5C3, a};
    endfunction : pat
    // Write data goes out one cycle after its command, as the data phase trails
    task automatic op(input logic [15:0] a, input logic wr_n, input logic adv, input logic [3:0] ln,
        input logic [31:0] d, input logic sel);
        wr_on = pend;
        wr_word = pdat;
        pend = !wr_n;
        pdat = d;
        request = '{a, LO, sel, LO, wr_n, ln, adv};
        @(negedge ref_clk);
    endtask : op
    task automatic t_lanes;
        op(16'h0010, LO, LO, 4'h0, 32'h11223344, HI);
        op(16'h0010, LO, LO, 4'hA, 32'hAABBCCDD, HI);
        op(16'h0010, HI, LO, 4'hF, 32'h0, HI);
        cmp("lane merge", 32'h11BB33DD, data_out);
        cmp("read drive", 32'h0, 32'(data_oe_n));
    endtask : t_lanes
    task automatic t_burst(input logic [15:0] s, input logic il);
        for (int i = 0; i < 4; i++) op(16'h0020, LO, i != 0, 4'h0, pat(16'h0020 | 16'(i)), HI);
        for (int i = 0; i < 4; i++) begin
            op(s, HI, i != 0, 4'hF, 32'h0, HI);
            cmp("burst word", pat({s[15:2], il ? s[1:0] ^ 2'(i) : s[1:0] + 2'(i)}), data_out);
        end
    endtask : t_burst
    task automatic t_freeze;
        op(16'h0021, HI, LO, 4'hF, 32'h0, HI);
        clock_qualify_n = HI;
        op(16'h0022, LO, LO, 4'h0, 32'h0, HI);
        cmp("frozen word", pat(16'h0021), data_out);
        clock_qualify_n = LO;
        op(16'h0022, HI, LO, 4'hF, 32'h0, HI);
        cmp("skipped write", pat(16'h0022), data_out);
    endtask : t_freeze
    task automatic t_select;
        op(16'h0020, HI, LO, 4'hF, 32'h0, LO);
        cmp("deselect", 32'h1, 32'(data_oe_n));
        op(16'h0020, HI, LO, 4'hF, 32'h0, HI);
        cmp("emerge", 32'h1, 32'(data_oe_n));
        output_enable_n = HI;
        op(16'h0021, HI, LO, 4'hF, 32'h0, HI);
        cmp("enable off", 32'h1, 32'(data_oe_n));
        output_enable_n = LO;
        #1;
        cmp("enable on", 32'h0, 32'(data_oe_n));
        cmp("async word", pat(16'h0021), data_out);
    endtask : t_select
    initial begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = HI;
        t_lanes();
        t_burst(16'h0022, LO);
        t_freeze();
        resetn = LO;
        burst_interleaved = HI;
        @(negedge ref_clk);
        resetn = HI;
        t_burst(16'h0021, HI);
        t_select();
        conclude();
    end
endmodule : sync_flowthrough_burst_sram_tb
`default_nettype wire
